//--- design/ppmc_map.vh
`ifndef PPMC_MAP_VH
`define PPMC_MAP_VH

// register byte offsets
`define PPMC_OFF_CHIP_STAT   8'h00
`define PPMC_OFF_PORT_CTRL   8'h10
`define PPMC_OFF_PORT_STAT   8'h20

// port control fields
`define PPMC_CTL_FIBER       0
`define PPMC_CTL_AUTONEG     1
`define PPMC_CTL_FAR_FAULT   2
`define PPMC_CTL_ENC_BYPASS  3
`define PPMC_CTL_SCR_BYPASS  4
`define PPMC_CTL_SLOW_DIS    5
`define PPMC_CTL_WIDTH       6
`define PPMC_CTL_RESET       6'h02

// port status fields
`define PPMC_PST_FIBER       0
`define PPMC_PST_AUTONEG     1
`define PPMC_PST_FAR_FAULT   2
`define PPMC_PST_ENC_BYPASS  3
`define PPMC_PST_SCR_BYPASS  4
`define PPMC_PST_SLOW_EN     5
`define PPMC_PST_SIG_DET_EN  6
`define PPMC_PST_SPEED_FAST  7
`define PPMC_PST_ON_BUS_A    8
`define PPMC_PST_ON_BUS_B    9

// chip status fields
`define PPMC_CST_SLOW_EXT    0
`define PPMC_CST_SYNTH_ON    1
`define PPMC_CST_FAST_DIRECT 2
`define PPMC_CST_OSC_ON      3
`define PPMC_CST_LATCHED     4
`define PPMC_CST_BUSED       5
`define PPMC_CST_SMART       6

// clock rates and timing
`define PPMC_FAST_CLK_MHZ    25
`define PPMC_SLOW_CLK_MHZ    20
`define PPMC_CLK_PERIOD_NS   10
`define PPMC_SETTLE_CYCLES   4
`define PPMC_DETECT_TIME_NS  2000
`define PPMC_DETECT_CYCLES   ((`PPMC_DETECT_TIME_NS + `PPMC_CLK_PERIOD_NS - 1) / `PPMC_CLK_PERIOD_NS)
`define PPMC_MIN_TOGGLES     4

`endif

//--- design/ppmc_sync.v
`timescale 1ns/10ps
// three-stage pin synchroniser; output moves once stages two and three agree
module ppmc_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // pins and filtered result
    input  wire [WIDTH-1:0] pin,
    output reg  [WIDTH-1:0] level
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;

    // stage1 feeds stage2 only, so metastability never reaches the compare
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
            level  <= {WIDTH{1'b0}};
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= (stage2 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
        end
    end

endmodule

//--- design/ppmc_port_cfg.v
//
// Behaviour
// - fast transceiver 25 MHz, slow transceiver 20 MHz
// - slow clock from synthesizer by default
// - slow clock strap high selects external input
// - detect direct fast clock versus crystal
// - fiber per port by strap or register
// - fiber reuses data pins, enables signal detect
// - fiber forces config, ignores register bits
// - fiber enables far-end fault signaling
// - fiber bypasses line coder and scrambler
// - fiber disables autoneg and slow speed
// - smart mode, in bused mode only, shares lines, adds security
// - bused mode routes ports by speed
`timescale 1ns/10ps
`include "ppmc_map.vh"
module ppmc_port_cfg #(
    parameter NPORTS = 4
) (
    // clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output reg               pslverr,
    // straps and mode pins
    input  wire              external_slow_clock_strap,
    input  wire [NPORTS-1:0] fiber_mode_strap,
    input  wire              bused_mode_pin,
    input  wire              smart_mode_pin,
    input  wire              fast_clock_probe,
    // clock source controls
    output reg               fast_clock_direct,
    output reg               oscillator_enable,
    output reg               slow_clock_external,
    output reg               synthesizer_enable,
    // per port configuration
    input  wire [NPORTS-1:0] fiber_signal_detect,
    output reg  [NPORTS-1:0] fiber_active,
    output reg  [NPORTS-1:0] fiber_data_pins,
    output reg  [NPORTS-1:0] signal_detect_valid,
    output reg  [NPORTS-1:0] autoneg_enable,
    output reg  [NPORTS-1:0] far_end_fault_enable,
    output reg  [NPORTS-1:0] line_coder_bypass,
    output reg  [NPORTS-1:0] scrambler_bypass,
    output reg  [NPORTS-1:0] slow_speed_enable,
    // per port state from transceivers
    input  wire [NPORTS-1:0] port_speed_fast,
    input  wire [NPORTS-1:0] port_carrier,
    input  wire [NPORTS-1:0] port_collision,
    // system interface routing
    output reg  [NPORTS-1:0] port_on_bus_a,
    output reg  [NPORTS-1:0] port_on_bus_b,
    output reg  [NPORTS-1:0] port_tx_enable,
    output reg  [NPORTS-1:0] port_rx_enable,
    output reg  [NPORTS-1:0] port_security,
    // repeater side lines
    input  wire [NPORTS-1:0] shared_transmit_enable,
    input  wire [NPORTS-1:0] slow_transmit_enable,
    input  wire [NPORTS-1:0] shared_receive_enable,
    input  wire [NPORTS-1:0] slow_receive_enable,
    output reg  [NPORTS-1:0] shared_carrier_sense,
    output reg  [NPORTS-1:0] slow_carrier_sense,
    output reg  [NPORTS-1:0] shared_collision,
    output reg  [NPORTS-1:0] slow_collision
);

    localparam NSYNC = 4 + 6 * NPORTS;
    localparam [3:0] ST_SETTLE = 4'h1;
    localparam [3:0] ST_LATCH  = 4'h2;
    localparam [3:0] ST_DETECT = 4'h4;
    localparam [3:0] ST_RUN    = 4'h8;
    localparam [15:0] SETTLE_LAST = `PPMC_SETTLE_CYCLES - 1;
    localparam [15:0] DETECT_LAST = `PPMC_DETECT_CYCLES - 1;
    localparam [7:0]  MIN_TOGGLES = `PPMC_MIN_TOGGLES;

    // register index decode for a block of per-port words
    function port_hit;
        input [7:0] addr;
        input [7:0] base;
        begin
            port_hit = (addr[7:4] == base[7:4]) && (addr[1:0] == 2'h0)
                       && ({28'h0000000, addr[3:2]} < NPORTS);
        end
    endfunction

    wire [NSYNC-1:0] pins_raw;
    wire [NSYNC-1:0] pins;
    wire             s_slow_strap;
    wire             s_bused;
    wire             s_smart;
    wire             s_probe;
    wire [NPORTS-1:0] s_fiber_strap;
    wire [NPORTS-1:0] s_sig_det;
    wire [NPORTS-1:0] s_tx_fast;
    wire [NPORTS-1:0] s_tx_slow;
    wire [NPORTS-1:0] s_rx_fast;
    wire [NPORTS-1:0] s_rx_slow;

    // every pin is asynchronous to pclk
    assign pins_raw = {slow_receive_enable, shared_receive_enable, slow_transmit_enable,
                       shared_transmit_enable, fiber_signal_detect, fiber_mode_strap,
                       fast_clock_probe, smart_mode_pin, bused_mode_pin,
                       external_slow_clock_strap};

    ppmc_sync #(
        .WIDTH (NSYNC)
    ) ppmc_sync_i (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (pins_raw),
        .level   (pins)
    );

    assign s_slow_strap  = pins[0];
    assign s_bused       = pins[1];
    assign s_smart       = pins[2];
    assign s_probe       = pins[3];
    assign s_fiber_strap = pins[4 +: NPORTS];
    assign s_sig_det     = pins[4 + NPORTS +: NPORTS];
    assign s_tx_fast     = pins[4 + 2 * NPORTS +: NPORTS];
    assign s_tx_slow     = pins[4 + 3 * NPORTS +: NPORTS];
    assign s_rx_fast     = pins[4 + 4 * NPORTS +: NPORTS];
    assign s_rx_slow     = pins[4 + 5 * NPORTS +: NPORTS];

    // startup sequencer
    reg [3:0]  state;
    reg [3:0]  next_state;
    reg [15:0] cycle_cnt;
    reg [7:0]  toggle_cnt;
    reg        probe_last;
    reg        straps_latched;
    reg        slow_strap_hold;
    reg [NPORTS-1:0] fiber_strap_hold;

    always @* begin
        next_state = state;
        case (state)
            ST_SETTLE: begin
                if (cycle_cnt == SETTLE_LAST)
                    next_state = ST_LATCH;
            end
            ST_LATCH:  next_state = ST_DETECT;
            ST_DETECT: begin
                if (cycle_cnt == DETECT_LAST)
                    next_state = ST_RUN;
            end
            ST_RUN:    next_state = ST_RUN;
            default:   next_state = ST_SETTLE;
        endcase
    end

    // waits for the synchroniser to fill before trusting strap levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state            <= ST_SETTLE;
            cycle_cnt        <= 16'h0000;
            toggle_cnt       <= 8'h00;
            probe_last       <= 1'b0;
            straps_latched   <= 1'b0;
            slow_strap_hold  <= 1'b0;
            fiber_strap_hold <= {NPORTS{1'b0}};
            fast_clock_direct   <= 1'b0;
            oscillator_enable   <= 1'b1;
            slow_clock_external <= 1'b0;
            synthesizer_enable  <= 1'b1;
        end else begin
            state      <= next_state;
            probe_last <= s_probe;
            cycle_cnt  <= (next_state != state) ? 16'h0000 : cycle_cnt + 16'h0001;
            case (state)
                ST_LATCH: begin
                    straps_latched   <= 1'b1;
                    slow_strap_hold  <= s_slow_strap;
                    fiber_strap_hold <= s_fiber_strap;
                    slow_clock_external <= s_slow_strap;
                    synthesizer_enable  <= ~s_slow_strap;
                    toggle_cnt <= 8'h00;
                end
                ST_DETECT: begin
                    // saturate so a fast probe cannot wrap back below the threshold
                    if ((s_probe != probe_last) && (toggle_cnt != 8'hff))
                        toggle_cnt <= toggle_cnt + 8'h01;
                    if (cycle_cnt == DETECT_LAST) begin
                        fast_clock_direct <= (toggle_cnt >= MIN_TOGGLES);
                        oscillator_enable <= (toggle_cnt < MIN_TOGGLES);
                    end
                end
                default: begin
                    toggle_cnt <= toggle_cnt;
                end
            endcase
        end
    end

    // apb register file, zero wait states
    reg [`PPMC_CTL_WIDTH-1:0] port_ctrl [0:NPORTS-1];
    wire        acc;
    wire        hit_ctrl;
    wire        hit_stat;
    wire        hit_chip;
    wire [1:0]  sel;
    reg  [31:0] rd_mux;

    assign pready   = 1'b1;
    assign acc      = psel & penable;
    assign sel      = paddr[3:2];
    assign hit_ctrl = port_hit(paddr, `PPMC_OFF_PORT_CTRL);
    assign hit_stat = port_hit(paddr, `PPMC_OFF_PORT_STAT);
    assign hit_chip = (paddr == `PPMC_OFF_CHIP_STAT);

    // control words stay writable in fiber mode; the override acts downstream
    genvar g;
    generate
        for (g = 0; g < NPORTS; g = g + 1) begin : g_ctrl
            always @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    port_ctrl[g] <= `PPMC_CTL_RESET;
                else if (acc && pwrite && hit_ctrl && (sel == g))
                    port_ctrl[g] <= pwdata[`PPMC_CTL_WIDTH-1:0];
            end
        end
    endgenerate

    // read data select
    always @* begin
        rd_mux = 32'h00000000;
        if (hit_chip) begin
            rd_mux[`PPMC_CST_SLOW_EXT]    = slow_clock_external;
            rd_mux[`PPMC_CST_SYNTH_ON]    = synthesizer_enable;
            rd_mux[`PPMC_CST_FAST_DIRECT] = fast_clock_direct;
            rd_mux[`PPMC_CST_OSC_ON]      = oscillator_enable;
            rd_mux[`PPMC_CST_LATCHED]     = straps_latched;
            rd_mux[`PPMC_CST_BUSED]       = s_bused;
            rd_mux[`PPMC_CST_SMART]       = s_smart;
        end else if (hit_ctrl) begin
            rd_mux[`PPMC_CTL_WIDTH-1:0] = port_ctrl[sel];
        end else if (hit_stat) begin
            rd_mux[`PPMC_PST_FIBER]      = fiber_active[sel];
            rd_mux[`PPMC_PST_AUTONEG]    = autoneg_enable[sel];
            rd_mux[`PPMC_PST_FAR_FAULT]  = far_end_fault_enable[sel];
            rd_mux[`PPMC_PST_ENC_BYPASS] = line_coder_bypass[sel];
            rd_mux[`PPMC_PST_SCR_BYPASS] = scrambler_bypass[sel];
            rd_mux[`PPMC_PST_SLOW_EN]    = slow_speed_enable[sel];
            rd_mux[`PPMC_PST_SIG_DET_EN] = fiber_data_pins[sel];
            rd_mux[`PPMC_PST_SPEED_FAST] = port_speed_fast[sel];
            rd_mux[`PPMC_PST_ON_BUS_A]   = port_on_bus_a[sel];
            rd_mux[`PPMC_PST_ON_BUS_B]   = port_on_bus_b[sel];
        end
    end

    // read data and error are registered in the setup cycle for the access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= ~(hit_ctrl | ((hit_stat | hit_chip) & ~pwrite));
        end else if (!psel) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // per port fiber override and system interface routing
    generate
        for (g = 0; g < NPORTS; g = g + 1) begin : g_port
            wire fa;
            wire fast;
            wire separate;
            assign fa       = fiber_strap_hold[g] | port_ctrl[g][`PPMC_CTL_FIBER];
            assign fast     = port_speed_fast[g];
            assign separate = s_bused & ~s_smart;

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fiber_active[g]         <= 1'b0;
                    fiber_data_pins[g]      <= 1'b0;
                    signal_detect_valid[g]  <= 1'b0;
                    autoneg_enable[g]       <= 1'b0;
                    far_end_fault_enable[g] <= 1'b0;
                    line_coder_bypass[g]    <= 1'b0;
                    scrambler_bypass[g]     <= 1'b0;
                    slow_speed_enable[g]    <= 1'b0;
                    port_on_bus_a[g]        <= 1'b0;
                    port_on_bus_b[g]        <= 1'b0;
                    port_tx_enable[g]       <= 1'b0;
                    port_rx_enable[g]       <= 1'b0;
                    port_security[g]        <= 1'b0;
                    shared_carrier_sense[g] <= 1'b0;
                    slow_carrier_sense[g]   <= 1'b0;
                    shared_collision[g]     <= 1'b0;
                    slow_collision[g]       <= 1'b0;
                end else begin
                    fiber_active[g]         <= fa;
                    fiber_data_pins[g]      <= fa;
                    signal_detect_valid[g]  <= fa & s_sig_det[g];
                    // register bits only count while the port is on copper
                    autoneg_enable[g]       <= ~fa & port_ctrl[g][`PPMC_CTL_AUTONEG];
                    far_end_fault_enable[g] <= fa | port_ctrl[g][`PPMC_CTL_FAR_FAULT];
                    line_coder_bypass[g]    <= fa | port_ctrl[g][`PPMC_CTL_ENC_BYPASS];
                    scrambler_bypass[g]     <= fa | port_ctrl[g][`PPMC_CTL_SCR_BYPASS];
                    slow_speed_enable[g]    <= ~fa & ~port_ctrl[g][`PPMC_CTL_SLOW_DIS];
                    port_on_bus_a[g]        <= s_bused & fast;
                    port_on_bus_b[g]        <= s_bused & ~fast;
                    port_security[g]        <= s_bused & s_smart & s_tx_slow[g];
                    // smart mode has one transmit enable line for all ports
                    if (s_bused && s_smart) begin
                        port_tx_enable[g]       <= s_tx_fast[0];
                        port_rx_enable[g]       <= s_rx_fast[g];
                        shared_carrier_sense[g] <= port_carrier[g];
                        shared_collision[g]     <= port_collision[g];
                        slow_carrier_sense[g]   <= 1'b0;
                        slow_collision[g]       <= 1'b0;
                    end else if (separate) begin
                        port_tx_enable[g]       <= fast ? s_tx_fast[g] : s_tx_slow[g];
                        port_rx_enable[g]       <= fast ? s_rx_fast[g] : s_rx_slow[g];
                        shared_carrier_sense[g] <= port_carrier[g] & fast;
                        shared_collision[g]     <= port_collision[g] & fast;
                        slow_carrier_sense[g]   <= port_carrier[g] & ~fast;
                        slow_collision[g]       <= port_collision[g] & ~fast;
                    end else begin
                        port_tx_enable[g]       <= s_tx_fast[g];
                        port_rx_enable[g]       <= s_rx_fast[g];
                        shared_carrier_sense[g] <= port_carrier[g];
                        shared_collision[g]     <= port_collision[g];
                        slow_carrier_sense[g]   <= 1'b0;
                        slow_collision[g]       <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // clock rates are fixed by the sources above; kept here as named figures
    localparam [7:0] FAST_MHZ = `PPMC_FAST_CLK_MHZ;
    localparam [7:0] SLOW_MHZ = `PPMC_SLOW_CLK_MHZ;

endmodule

//--- dv/ppmc_port_cfg_properties.sv
`timescale 1ns/10ps
module ppmc_port_cfg_properties #(
    parameter NPORTS = 4
) (
    // clock, reset and bus
    input logic              pclk, presetn, psel, penable, pwrite, pslverr,
    input logic [7:0]        paddr,
    input logic [31:0]       pwdata,
    // clock source controls
    input logic              fast_clock_direct, oscillator_enable,
    input logic              slow_clock_external, synthesizer_enable,
    // per port configuration and routing
    input logic [NPORTS-1:0] fiber_active, fiber_data_pins, signal_detect_valid,
    input logic [NPORTS-1:0] autoneg_enable, far_end_fault_enable, slow_speed_enable,
    input logic [NPORTS-1:0] line_coder_bypass, scrambler_bypass, port_speed_fast,
    input logic [NPORTS-1:0] port_on_bus_a, port_on_bus_b, slow_carrier_sense, slow_collision
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // plain net so $past sees a signal, not an expression
    wire [NPORTS-1:0] on_bus = port_on_bus_a | port_on_bus_b;
    property p_fiber_off;
        (fiber_active & (autoneg_enable | slow_speed_enable)) == 0;
    endproperty
    a_fiber_off: assert property (p_fiber_off) else $error("fiber port kept autoneg");
    property p_fef;
        (fiber_active & ~far_end_fault_enable) == 0;
    endproperty
    a_fef: assert property (p_fef) else $error("fiber port without far fault");
    property p_bypass;
        (fiber_active & ~(line_coder_bypass & scrambler_bypass)) == 0;
    endproperty
    a_bypass: assert property (p_bypass) else $error("fiber port not bypassed");
    property p_pins;
        fiber_data_pins == fiber_active && (signal_detect_valid & ~fiber_active) == 0;
    endproperty
    a_pins: assert property (p_pins) else $error("data pins or detect not fiber");
    property p_sw_fiber;
        psel && penable && pwrite && paddr == 8'h14 && pwdata[0] |-> ##[1:2] fiber_active[1];
    endproperty
    a_sw_fiber: assert property (p_sw_fiber) else $error("register fiber ignored");
    property p_slow_src;
        slow_clock_external != synthesizer_enable;
    endproperty
    a_slow_src: assert property (p_slow_src) else $error("slow clock source clash");
    property p_fast_src;
        fast_clock_direct != oscillator_enable;
    endproperty
    a_fast_src: assert property (p_fast_src) else $error("fast clock source clash");
    property p_strap_hold;
        !$fell(slow_clock_external);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap followed late");
    property p_bus_split;
        $stable(port_speed_fast) && on_bus != 0 |->
            port_on_bus_a == port_speed_fast && port_on_bus_b == ~port_speed_fast;
    endproperty
    a_bus_split: assert property (p_bus_split) else $error("port on wrong bus");
    property p_slow_quiet;
        on_bus == 0 && $past(on_bus) == 0 |-> (slow_carrier_sense | slow_collision) == 0;
    endproperty
    a_slow_quiet: assert property (p_slow_quiet) else $error("slow lines used unbused");
    property p_ro_write;
        psel && !penable && pwrite && paddr == 8'h00 |=> pslverr;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("status write accepted");
endmodule
bind ppmc_port_cfg ppmc_port_cfg_properties #(.NPORTS(NPORTS)) ppmc_port_cfg_properties_i (.*);

//--- dv/ppmc_rep_model.sv
`timescale 1ns/10ps
module ppmc_rep_model #(
    parameter N = 4
) (
    // clock and reset
    input  wire  pclk, presetn,
    // requests from the bench
    input  wire  [N-1:0] rep_req, rep_fast, rep_sec,
    input  wire          rep_smart,
    // repeater pins
    output logic [N-1:0] shared_transmit_enable, slow_transmit_enable,
    output logic [N-1:0] shared_receive_enable, slow_receive_enable
);
    logic [N-1:0] churn;
    // in smart mode the unused lines carry a moving pattern, so a design reading them cannot pass
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            churn <= 4'h5;
            shared_transmit_enable <= 4'h0;
            slow_transmit_enable <= 4'h0;
            shared_receive_enable <= 4'h0;
            slow_receive_enable <= 4'h0;
        end else if (rep_smart) begin
            churn <= ~churn;
            shared_transmit_enable <= {churn[N-1:1], rep_req[0]};
            shared_receive_enable <= rep_req;
            slow_transmit_enable <= rep_sec;
            slow_receive_enable <= churn;
        end else begin
            shared_transmit_enable <= rep_req & rep_fast;
            shared_receive_enable <= rep_req & rep_fast;
            slow_transmit_enable <= rep_req & ~rep_fast;
            slow_receive_enable <= rep_req & ~rep_fast;
        end
    end
endmodule

//--- dv/phy_port_mode_clock_config_tb.sv
`timescale 1ns/10ps
module phy_port_mode_clock_config_tb;
    localparam N = 4;
    // bus, straps and pins
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    wire  [31:0]  prdata;
    wire          pready, pslverr;
    logic         external_slow_clock_strap = 1'b0, bused_mode_pin = 1'b0;
    logic         smart_mode_pin = 1'b0, fast_clock_probe = 1'b0, probe_run = 1'b1;
    logic [N-1:0] fiber_mode_strap = 4'h5, fiber_signal_detect = 4'h0, port_speed_fast = 4'h0;
    logic [N-1:0] port_carrier = 4'h0, port_collision = 4'h0;
    // repeater model requests
    logic [N-1:0] rep_req = 4'h0, rep_fast = 4'hf, rep_sec = 4'h0;
    logic         rep_smart = 1'b0;
    // design and repeater model outputs
    wire          fast_clock_direct, oscillator_enable, slow_clock_external, synthesizer_enable;
    wire  [N-1:0] fiber_active, fiber_data_pins, signal_detect_valid, autoneg_enable;
    wire  [N-1:0] far_end_fault_enable, line_coder_bypass, scrambler_bypass, slow_speed_enable;
    wire  [N-1:0] port_on_bus_a, port_on_bus_b, port_tx_enable, port_rx_enable, port_security;
    wire  [N-1:0] shared_carrier_sense, slow_carrier_sense, shared_collision, slow_collision;
    wire  [N-1:0] shared_transmit_enable, slow_transmit_enable;
    wire  [N-1:0] shared_receive_enable, slow_receive_enable;
    int           error_cnt = 0, n_tests = 0, cyc = 0;
    ppmc_port_cfg #(.NPORTS(N)) ppmc_port_cfg_i (.*);
    ppmc_rep_model #(.N(N)) ppmc_rep_model_i (.*);
    initial begin
        forever #5 pclk = ~pclk;
    end
    // probe toggles as a directly applied clock would; held still means crystal
    always @(posedge pclk) begin
        if (probe_run && cyc[1:0] == 2'b00) fast_clock_probe <= ~fast_clock_probe;
    end
    // hang guard, well above the roughly 640 cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high at an edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp_rd, input logic exp_err);
        logic [31:0] r;
        logic        e;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(e, exp_err);
        if (!w) chk(r, exp_rd);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_straps();
        repeat (260) @(posedge pclk);
        chk(synthesizer_enable, 1);
        chk(slow_clock_external, 0);
        chk(fast_clock_direct, 1);
        chk(oscillator_enable, 0);
        chk(fiber_active, 4'h5);
        fiber_mode_strap <= 4'h0;
        external_slow_clock_strap <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(fiber_active, 4'h5);
        chk(slow_clock_external, 0);
        $display("test straps done");
    endtask
    task automatic t_fiber();
        fiber_signal_detect <= 4'hf;
        acc(1'b1, 8'h10, 32'h02, 32'h0, 1'b0);
        acc(1'b1, 8'h14, 32'h01, 32'h0, 1'b0);
        repeat (10) @(posedge pclk);
        chk(fiber_active, 4'h7);
        chk(fiber_data_pins, 4'h7);
        chk(signal_detect_valid, 4'h7);
        chk(autoneg_enable, 4'h8);
        chk(slow_speed_enable, 4'h8);
        chk(far_end_fault_enable, 4'h7);
        chk(line_coder_bypass, 4'h7);
        chk(scrambler_bypass, 4'h7);
        acc(1'b0, 8'h24, 32'h0, 32'h5d, 1'b0);
        $display("test fiber done");
    endtask
    task automatic t_regs();
        acc(1'b0, 8'h00, 32'h0, 32'h16, 1'b0);
        acc(1'b1, 8'h00, 32'hff, 32'h0, 1'b1);
        acc(1'b1, 8'h24, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 8'h04, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        acc(1'b1, 8'h1c, 32'hffff_ff3c, 32'h0, 1'b0);
        acc(1'b0, 8'h1c, 32'h0, 32'h3c, 1'b0);
        repeat (3) @(posedge pclk);
        chk(autoneg_enable, 4'h0);
        chk(far_end_fault_enable, 4'hf);
        $display("test registers done");
    endtask
    task automatic t_normal();
        rep_req <= 4'h3;
        port_carrier <= 4'ha;
        port_collision <= 4'h6;
        repeat (10) @(posedge pclk);
        chk(port_tx_enable, 4'h3);
        chk(port_rx_enable, 4'h3);
        chk(shared_carrier_sense, 4'ha);
        chk(shared_collision, 4'h6);
        chk({slow_carrier_sense, slow_collision, port_on_bus_a, port_on_bus_b}, 0);
        $display("test normal done");
    endtask
    task automatic t_separate();
        bused_mode_pin <= 1'b1;
        port_speed_fast <= 4'h3;
        rep_fast <= 4'h3;
        rep_req <= 4'hf;
        port_carrier <= 4'hf;
        port_collision <= 4'hf;
        repeat (10) @(posedge pclk);
        chk({port_on_bus_a, port_on_bus_b}, 8'h3c);
        chk({port_tx_enable, port_rx_enable}, 8'hff);
        chk({shared_carrier_sense, slow_carrier_sense}, 8'h3c);
        chk({shared_collision, slow_collision}, 8'h3c);
        $display("test separate done");
    endtask
    task automatic t_smart();
        smart_mode_pin <= 1'b1;
        rep_smart <= 1'b1;
        rep_req <= 4'h5;
        rep_sec <= 4'h9;
        repeat (10) @(posedge pclk);
        chk({port_tx_enable, port_rx_enable}, 8'hf5);
        chk(port_security, 4'h9);
        chk(shared_carrier_sense, 4'hf);
        chk({slow_carrier_sense, slow_collision}, 8'h00);
        rep_req <= 4'h4;
        repeat (10) @(posedge pclk);
        chk(port_tx_enable, 4'h0);
        $display("test smart done");
    endtask
    task automatic t_xtal();
        bused_mode_pin <= 1'b0;
        smart_mode_pin <= 1'b0;
        probe_run <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (260) @(posedge pclk);
        chk({slow_clock_external, synthesizer_enable}, 2'b10);
        chk({fast_clock_direct, oscillator_enable}, 2'b01);
        chk(fiber_active, 4'h0);
        chk(autoneg_enable, 4'hf);
        acc(1'b0, 8'h00, 32'h0, 32'h19, 1'b0);
        $display("test crystal done");
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_straps();
        t_fiber();
        t_regs();
        t_normal();
        t_separate();
        t_smart();
        t_xtal();
        test_done();
    end
endmodule
